// ===== logic/pbmux_pkg.sv
package pbmux_pkg;

	////////////////////////////////////////////////////////////////////////
	// Pin indices, also the bit index into every per-pin vector
	localparam int NUM_PINS = 9;
	localparam int PIN_PHASE_A = 0;
	localparam int PIN_PHASE_B = 1;
	localparam int PIN_INDEX = 2;
	localparam int PIN_HOME = 3;
	localparam int PIN_SPI_ZERO_SERIAL_CLOCK_PIN = 4;
	localparam int PIN_SPI_ZERO_MASTER_OUT_PIN = 5;
	localparam int PIN_SPI_ZERO_MASTER_IN_PIN = 6;
	localparam int PIN_SS0 = 7;
	localparam int PIN_PWM0 = 8;

	////////////////////////////////////////////////////////////////////////
	// Function select codes
	localparam int FN_W = 3;
	localparam int MAX_FN = 4;
	localparam logic [FN_W-1:0] FN_0 = 3'h0;
	localparam logic [FN_W-1:0] FN_1 = 3'h1;
	localparam logic [FN_W-1:0] FN_2 = 3'h2;
	localparam logic [FN_W-1:0] FN_3 = 3'h3;
	localparam logic [FN_W-1:0] FN_NONE = 3'h7;

	// Slot holding each function on the shared pins
	localparam int SLOT_PRIMARY = 0;
	localparam int SLOT_TIMER = 1;
	localparam int SLOT_QUAD_GPIO = 2;
	localparam int SLOT_CLK_MON = 3;
	localparam int SLOT_SPI_GPIO = 1;
	localparam int SLOT_SCI = 1;
	localparam int SLOT_SCI_GPIO = 2;
	localparam int SLOT_PWM_GPIO = 1;

	// Number of functions offered per pin, pin 0 in the low field
	localparam logic [NUM_PINS-1:0][FN_W-1:0] PIN_FN_CNT = {
		3'h2, 3'h3, 3'h3, 3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4};

	// Reset selections per variant
	localparam logic [NUM_PINS-1:0][FN_W-1:0] PIN_RST_FULL = {
		FN_0, FN_0, FN_0, FN_0, FN_0, FN_0, FN_0, FN_0, FN_0};
	localparam logic [NUM_PINS-1:0][FN_W-1:0] PIN_RST_REDUCED = {
		FN_NONE, FN_0, FN_0, FN_0, FN_0, FN_NONE, FN_NONE, FN_NONE, FN_NONE};

	////////////////////////////////////////////////////////////////////////
	// Clock output select bits
	localparam int CLKO_W = 4;
	localparam int CLKO_OSC = 0;
	localparam int CLKO_SYS2 = 1;
	localparam int CLKO_SYS = 2;
	localparam int CLKO_PRE = 3;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	localparam int TMR_W = 4;
	localparam logic PAD_IDLE_IN = 1'b1;

	typedef struct packed {
		logic [MAX_FN-1:0] out;
		logic [MAX_FN-1:0] oe;
	} pbmux_fn_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pu;
	} pbmux_pad_t;

	localparam pbmux_pad_t PAD_RST = '{out: 1'b0, oe: 1'b0, pu: 1'b1};

	typedef struct packed {
		logic master;
		logic sclk;
		logic mosi;
		logic miso;
	} pbmux_spi_out_t;

	typedef struct packed {
		logic sclk;
		logic mosi;
		logic miso;
		logic select_n;
	} pbmux_spi_in_t;

endpackage

// ===== logic/pbmux_pin_cell.sv
`timescale 1ns/1ps

module pbmux_pin_cell #(
	parameter logic [2:0] FN_CNT = 3'h4
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic [pbmux_pkg::FN_W-1:0] sel_i,
	input wire pbmux_pkg::pbmux_fn_t fn_i,
	input wire logic pull_en_i,
	input wire logic pad_i,
	output pbmux_pkg::pbmux_pad_t pad_o,
	output logic [pbmux_pkg::MAX_FN-1:0] fn_in_o
);
	import pbmux_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Unknown codes park the pin as an undriven input
	wire sel_ok = (sel_i < FN_CNT);
	wire [1:0] slot = sel_i[1:0];
	wire drv_nxt = sel_ok & fn_i.oe[slot];
	wire out_nxt = fn_i.out[slot];
	wire pu_nxt = pull_en_i & ~drv_nxt;

	pbmux_pad_t pad_r;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			pad_r <= PAD_RST;
		end else begin
			pad_r <= '{out: out_nxt, oe: drv_nxt, pu: pu_nxt};
		end
	end

	assign pad_o = pad_r;

	// Unselected functions see the idle pulled-up level
	genvar k;
	generate
		for (k = 0; k < MAX_FN; k++) begin : g_in
			assign fn_in_o[k] = (sel_ok && slot == k) ? pad_i : PAD_IDLE_IN;
		end
	endgenerate

endmodule

// ===== logic/pbmux_top.sv
`timescale 1ns/1ps

module pbmux_top (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic variant_full_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0][pbmux_pkg::FN_W-1:0] fn_sel_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] fn_sel_load_i,
	output logic [pbmux_pkg::NUM_PINS-1:0][pbmux_pkg::FN_W-1:0] fn_sel_o,
	input wire logic [pbmux_pkg::CLKO_W-1:0] clock_output_select_register_i,
	input wire logic oscillator_clock_monitor_i,
	input wire logic second_system_clock_monitor_i,
	input wire logic system_clock_monitor_i,
	input wire logic prescaler_clock_monitor_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] gpio_out_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] gpio_dir_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] pull_en_i,
	output logic [pbmux_pkg::NUM_PINS-1:0] gpio_in_o,
	input wire logic [pbmux_pkg::TMR_W-1:0] timer_a_out_i,
	input wire logic [pbmux_pkg::TMR_W-1:0] timer_a_oe_i,
	output logic [pbmux_pkg::TMR_W-1:0] timer_a_in_o,
	output logic decoder_phase_a_input_o,
	output logic decoder_phase_b_input_o,
	output logic decoder_index_input_o,
	output logic decoder_home_input_o,
	input wire pbmux_pkg::pbmux_spi_out_t spi_out_i,
	output pbmux_pkg::pbmux_spi_in_t spi_in_o,
	output logic spi_slave_selected_o,
	input wire logic serial_one_transmit_output_i,
	output logic serial_one_receive_input_o,
	input wire logic pwm_channel_zero_output_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] pad_i,
	output pbmux_pkg::pbmux_pad_t [pbmux_pkg::NUM_PINS-1:0] pads_o
);
	import pbmux_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Function selection state

	logic [NUM_PINS-1:0][FN_W-1:0] sel_r;
	logic [NUM_PINS-1:0][FN_W-1:0] sel_nxt;
	logic [NUM_PINS-1:0][FN_W-1:0] sel_rst;

	// Strap is sampled on every clock edge while reset is held, so the last one before release counts
	assign sel_rst = variant_full_i ? PIN_RST_FULL : PIN_RST_REDUCED;

	genvar p;
	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_sel
			assign sel_nxt[p] = fn_sel_load_i[p] ? fn_sel_i[p] : sel_r[p];
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			sel_r <= sel_rst;
		end else begin
			sel_r <= sel_nxt;
		end
	end

	assign fn_sel_o = sel_r;

	////////////////////////////////////////////////////////////////////////
	// Inputs seen through the pins, one register stage

	logic [NUM_PINS-1:0][MAX_FN-1:0] fn_in;
	logic [NUM_PINS-1:0][MAX_FN-1:0] fn_in_r;

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			fn_in_r <= '1;
		end else begin
			fn_in_r <= fn_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// SPI slave select and data direction

	// Select is active low; a pin not in SPI function reads idle high
	wire ss_active = ~fn_in_r[PIN_SS0][SLOT_PRIMARY];
	wire slave_mode = ~spi_out_i.master;
	wire miso_drive = slave_mode & ss_active;
	wire master_drive = spi_out_i.master;

	assign spi_slave_selected_o = slave_mode & ss_active;

	////////////////////////////////////////////////////////////////////////
	// Per-pin function tables, slot 3 down to slot 0

	pbmux_fn_t [NUM_PINS-1:0] fn_tab;

	// Clock monitors only drive when the output select enables them
	assign fn_tab[PIN_PHASE_A] = '{
		out: {oscillator_clock_monitor_i, gpio_out_i[PIN_PHASE_A],
			timer_a_out_i[PIN_PHASE_A], 1'b0},
		oe: {clock_output_select_register_i[CLKO_OSC], gpio_dir_i[PIN_PHASE_A],
			timer_a_oe_i[PIN_PHASE_A], 1'b0}};

	assign fn_tab[PIN_PHASE_B] = '{
		out: {second_system_clock_monitor_i, gpio_out_i[PIN_PHASE_B],
			timer_a_out_i[PIN_PHASE_B], 1'b0},
		oe: {clock_output_select_register_i[CLKO_SYS2], gpio_dir_i[PIN_PHASE_B],
			timer_a_oe_i[PIN_PHASE_B], 1'b0}};

	assign fn_tab[PIN_INDEX] = '{
		out: {system_clock_monitor_i, gpio_out_i[PIN_INDEX],
			timer_a_out_i[PIN_INDEX], 1'b0},
		oe: {clock_output_select_register_i[CLKO_SYS], gpio_dir_i[PIN_INDEX],
			timer_a_oe_i[PIN_INDEX], 1'b0}};

	assign fn_tab[PIN_HOME] = '{
		out: {prescaler_clock_monitor_i, gpio_out_i[PIN_HOME],
			timer_a_out_i[PIN_HOME], 1'b0},
		oe: {clock_output_select_register_i[CLKO_PRE], gpio_dir_i[PIN_HOME],
			timer_a_oe_i[PIN_HOME], 1'b0}};

	// Clock and data share the same register stage, keeping the half-period skew
	assign fn_tab[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] = '{
		out: {2'b00, gpio_out_i[PIN_SPI_ZERO_SERIAL_CLOCK_PIN], spi_out_i.sclk},
		oe: {2'b00, gpio_dir_i[PIN_SPI_ZERO_SERIAL_CLOCK_PIN], master_drive}};

	assign fn_tab[PIN_SPI_ZERO_MASTER_OUT_PIN] = '{
		out: {2'b00, gpio_out_i[PIN_SPI_ZERO_MASTER_OUT_PIN], spi_out_i.mosi},
		oe: {2'b00, gpio_dir_i[PIN_SPI_ZERO_MASTER_OUT_PIN], master_drive}};

	assign fn_tab[PIN_SPI_ZERO_MASTER_IN_PIN] = '{
		out: {1'b0, gpio_out_i[PIN_SPI_ZERO_MASTER_IN_PIN], 1'b0, spi_out_i.miso},
		oe: {1'b0, gpio_dir_i[PIN_SPI_ZERO_MASTER_IN_PIN], 1'b0, miso_drive}};

	assign fn_tab[PIN_SS0] = '{
		out: {1'b0, gpio_out_i[PIN_SS0], serial_one_transmit_output_i, 1'b0},
		oe: {1'b0, gpio_dir_i[PIN_SS0], 1'b1, 1'b0}};

	assign fn_tab[PIN_PWM0] = '{
		out: {2'b00, gpio_out_i[PIN_PWM0], pwm_channel_zero_output_i},
		oe: {2'b00, gpio_dir_i[PIN_PWM0], 1'b1}};

	////////////////////////////////////////////////////////////////////////
	// Pad cells

	generate
		for (p = 0; p < NUM_PINS; p++) begin : g_pin
			pbmux_pin_cell #(
				.FN_CNT(PIN_FN_CNT[p])
			) u_cell (
				.clk_sys_i(clk_sys_i),
				.nrst_i(nrst_i),
				.sel_i(sel_r[p]),
				.fn_i(fn_tab[p]),
				.pull_en_i(pull_en_i[p]),
				.pad_i(pad_i[p]),
				.pad_o(pads_o[p]),
				.fn_in_o(fn_in[p])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Inputs back to the peripherals

	// Port bits read the pad level whichever direction is chosen
	assign gpio_in_o[PIN_PHASE_A] = fn_in_r[PIN_PHASE_A][SLOT_QUAD_GPIO];
	assign gpio_in_o[PIN_PHASE_B] = fn_in_r[PIN_PHASE_B][SLOT_QUAD_GPIO];
	assign gpio_in_o[PIN_INDEX] = fn_in_r[PIN_INDEX][SLOT_QUAD_GPIO];
	assign gpio_in_o[PIN_HOME] = fn_in_r[PIN_HOME][SLOT_QUAD_GPIO];
	assign gpio_in_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] = fn_in_r[PIN_SPI_ZERO_SERIAL_CLOCK_PIN][SLOT_SPI_GPIO];
	assign gpio_in_o[PIN_SPI_ZERO_MASTER_OUT_PIN] = fn_in_r[PIN_SPI_ZERO_MASTER_OUT_PIN][SLOT_SPI_GPIO];
	assign gpio_in_o[PIN_SPI_ZERO_MASTER_IN_PIN] = fn_in_r[PIN_SPI_ZERO_MASTER_IN_PIN][SLOT_SCI_GPIO];
	assign gpio_in_o[PIN_SS0] = fn_in_r[PIN_SS0][SLOT_SCI_GPIO];
	assign gpio_in_o[PIN_PWM0] = fn_in_r[PIN_PWM0][SLOT_PWM_GPIO];

	generate
		for (p = 0; p < TMR_W; p++) begin : g_tmr
			assign timer_a_in_o[p] = fn_in_r[p][SLOT_TIMER];
		end
	endgenerate

	assign decoder_phase_a_input_o = fn_in_r[PIN_PHASE_A][SLOT_PRIMARY];
	assign decoder_phase_b_input_o = fn_in_r[PIN_PHASE_B][SLOT_PRIMARY];
	assign decoder_index_input_o = fn_in_r[PIN_INDEX][SLOT_PRIMARY];
	assign decoder_home_input_o = fn_in_r[PIN_HOME][SLOT_PRIMARY];

	// Master ignores its own clock pin echo only by mode, not here
	assign spi_in_o = '{
		sclk: fn_in_r[PIN_SPI_ZERO_SERIAL_CLOCK_PIN][SLOT_PRIMARY],
		mosi: fn_in_r[PIN_SPI_ZERO_MASTER_OUT_PIN][SLOT_PRIMARY],
		miso: fn_in_r[PIN_SPI_ZERO_MASTER_IN_PIN][SLOT_PRIMARY],
		select_n: fn_in_r[PIN_SS0][SLOT_PRIMARY]};

	assign serial_one_receive_input_o = fn_in_r[PIN_SPI_ZERO_MASTER_IN_PIN][SLOT_SCI];

endmodule

// ===== sim/pbmux_monitor.sv
`timescale 1ns/1ps
module pbmux_monitor (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic variant_full_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0][pbmux_pkg::FN_W-1:0] fn_sel_o,
	input wire logic [pbmux_pkg::CLKO_W-1:0] clock_output_select_register_i,
	input wire logic system_clock_monitor_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] gpio_dir_i,
	input wire logic pwm_channel_zero_output_i,
	input wire pbmux_pkg::pbmux_spi_out_t spi_out_i,
	input wire logic spi_slave_selected_o,
	input wire pbmux_pkg::pbmux_pad_t [pbmux_pkg::NUM_PINS-1:0] pads_o
);
	import pbmux_pkg::*;
	logic [NUM_PINS-1:0] oe_v, pu_v;
	always_comb begin
		for (int k = 0; k < NUM_PINS; k++) begin
			oe_v[k] = pads_o[k].oe;
			pu_v[k] = pads_o[k].pu;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////////////
	// Reset checks must not be masked by the reset they watch
	property p_rst_pads;
		disable iff (1'b0) !nrst_i |=> oe_v == '0 && pu_v == '1;
	endproperty
	a_rst_pads: assert property (p_rst_pads) else $error("pad driven in reset");
	property p_rst_sel;
		disable iff (1'b0) !nrst_i |=>
			fn_sel_o == ($past(variant_full_i) ? PIN_RST_FULL : PIN_RST_REDUCED);
	endproperty
	a_rst_sel: assert property (p_rst_sel) else $error("bad reset selection");
	property p_gpio;
		fn_sel_o[PIN_INDEX] == FN_2 |=> pads_o[PIN_INDEX].oe == $past(gpio_dir_i[PIN_INDEX]);
	endproperty
	a_gpio: assert property (p_gpio) else $error("port direction ignored");
	property p_clkmon;
		fn_sel_o[PIN_INDEX] == FN_3 |=>
			pads_o[PIN_INDEX].oe == $past(clock_output_select_register_i[CLKO_SYS]) &&
			(!pads_o[PIN_INDEX].oe || pads_o[PIN_INDEX].out == $past(system_clock_monitor_i));
	endproperty
	a_clkmon: assert property (p_clkmon) else $error("clock monitor wrong");
	property p_sclk;
		fn_sel_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] == FN_0 |=> pads_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN].oe == $past(spi_out_i.master);
	endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock direction");
	// Equal delay on clock and data keeps the half period lead
	property p_spi_data;
		fn_sel_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] == FN_0 && fn_sel_o[PIN_SPI_ZERO_MASTER_OUT_PIN] == FN_0 && spi_out_i.master |=>
			pads_o[PIN_SPI_ZERO_MASTER_OUT_PIN].out == $past(spi_out_i.mosi) &&
			pads_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN].out == $past(spi_out_i.sclk);
	endproperty
	a_spi_data: assert property (p_spi_data) else $error("clock and data skewed");
	property p_miso;
		fn_sel_o[PIN_SPI_ZERO_MASTER_IN_PIN] == FN_0 && !spi_out_i.master |=>
			pads_o[PIN_SPI_ZERO_MASTER_IN_PIN].oe == $past(spi_slave_selected_o);
	endproperty
	a_miso: assert property (p_miso) else $error("slave data drive wrong");
	property p_pwm;
		fn_sel_o[PIN_PWM0] == FN_0 |=>
			pads_o[PIN_PWM0].oe && pads_o[PIN_PWM0].out == $past(pwm_channel_zero_output_i);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm output wrong");
	c_slave: cover property (spi_slave_selected_o);
	c_clkmon: cover property (fn_sel_o[PIN_INDEX] == FN_3 && oe_v[PIN_INDEX]);
	c_park: cover property (fn_sel_o[PIN_PWM0] == FN_NONE);
endmodule

bind pbmux_top pbmux_monitor mon_u (.*);

// ===== sim/pbmux_peer.sv
`timescale 1ns/1ps
module pbmux_peer (
	input wire logic clk_sys_i,
	input wire pbmux_pkg::pbmux_pad_t [pbmux_pkg::NUM_PINS-1:0] pads_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] drv_en_i,
	input wire logic [pbmux_pkg::NUM_PINS-1:0] drv_val_i,
	output logic [pbmux_pkg::NUM_PINS-1:0] pad_o
);
	import pbmux_pkg::*;
	// Floating pins wander so a stale level never reads as data
	logic [NUM_PINS-1:0] float_r = '0;
	always_ff @(posedge clk_sys_i) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int k = 0; k < NUM_PINS; k++) begin
			if (pads_i[k].oe) begin
				pad_o[k] = pads_i[k].out;
			end else if (drv_en_i[k]) begin
				pad_o[k] = drv_val_i[k];
			end else begin
				pad_o[k] = pads_i[k].pu ? 1'b1 : float_r[k];
			end
		end
	end
endmodule

// ===== sim/port_b_pin_function_mux_tb.sv
`timescale 1ns/1ps
module port_b_pin_function_mux_tb;
	import pbmux_pkg::*;
	logic clk_sys_i = 1'b0, nrst_i = 1'b0, variant_full_i = 1'b1, system_clock_monitor_i = 1'b1;
	logic oscillator_clock_monitor_i = 1'b1, second_system_clock_monitor_i = 1'b1;
	logic prescaler_clock_monitor_i = 1'b1, serial_one_transmit_output_i = 1'b0;
	logic pwm_channel_zero_output_i = 1'b1, spi_slave_selected_o, serial_one_receive_input_o;
	logic decoder_phase_a_input_o, decoder_phase_b_input_o, decoder_index_input_o;
	logic decoder_home_input_o;
	logic [NUM_PINS-1:0][FN_W-1:0] fn_sel_i = '0, fn_sel_o;
	logic [NUM_PINS-1:0] fn_sel_load_i = '0, gpio_out_i = '1, gpio_dir_i = '1, pull_en_i = '1;
	logic [NUM_PINS-1:0] gpio_in_o, pad_i, peer_en = 9'h00f, peer_val = '1;
	logic [CLKO_W-1:0] clock_output_select_register_i = '1;
	logic [TMR_W-1:0] timer_a_out_i = '0, timer_a_oe_i = '1, timer_a_in_o;
	pbmux_spi_out_t spi_out_i = '0;
	pbmux_spi_in_t spi_in_o;
	pbmux_pad_t [NUM_PINS-1:0] pads_o;
	logic [3:0] dec;
	int miscompares = 0, checked = 0;
	assign dec = {decoder_home_input_o, decoder_index_input_o, decoder_phase_b_input_o,
		decoder_phase_a_input_o};
	pbmux_top dut_u (.*);
	pbmux_peer peer_u (.clk_sys_i(clk_sys_i), .pads_i(pads_o), .drv_en_i(peer_en),
		.drv_val_i(peer_val), .pad_o(pad_i));
	always #2 clk_sys_i = ~clk_sys_i;
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t level %b expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_fn(input logic [FN_W-1:0] got, input logic [FN_W-1:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t selection %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic ld(input int p, input logic [FN_W-1:0] c);
		@(posedge clk_sys_i);
		fn_sel_i[p] <= c;
		fn_sel_load_i[p] <= 1'b1;
		@(posedge clk_sys_i);
		fn_sel_load_i[p] <= 1'b0;
		tick(2);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset(input logic full);
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		variant_full_i <= full;
		tick(5);
		for (int k = 0; k < NUM_PINS; k++) begin
			chk_bit(pads_o[k].oe | ~pads_o[k].pu, 1'b0);
			chk_fn(fn_sel_o[k], (full || (k >= PIN_SPI_ZERO_SERIAL_CLOCK_PIN && k <= PIN_SS0)) ? FN_0 : FN_NONE);
		end
		@(posedge clk_sys_i);
		nrst_i <= 1'b1;
		tick(2);
		chk_bit(pads_o[PIN_PWM0].oe, full);
	endtask
	// Every source active at once, so a wrong slot shows
	task automatic t_shared();
		for (int p = PIN_PHASE_A; p <= PIN_HOME; p++) begin
			for (int c = 0; c < 4; c++) begin
				ld(p, FN_W'(c));
				chk_bit(pads_o[p].oe, c != 0);
				chk_bit(c == 0 ? dec[p] : pads_o[p].out, c != 1);
				chk_bit(timer_a_in_o[p], c != 1);
			end
			@(posedge clk_sys_i);
			clock_output_select_register_i[p] <= 1'b0;
			tick(2);
			chk_bit(pads_o[p].oe, 1'b0);
		end
	endtask
	task automatic t_gpio();
		@(posedge clk_sys_i);
		peer_val[PIN_HOME:PIN_INDEX] <= 2'h0;
		ld(PIN_INDEX, FN_2);
		ld(PIN_HOME, FN_2);
		for (int d = 0; d < 2; d++) begin
			@(posedge clk_sys_i);
			gpio_dir_i[PIN_INDEX] <= d[0];
			gpio_dir_i[PIN_HOME] <= !d[0];
			tick(2);
			chk_bit(pads_o[PIN_INDEX].oe, d[0]);
			chk_bit(pads_o[PIN_HOME].oe, !d[0]);
			chk_bit(d[0] ? gpio_in_o[PIN_HOME] : gpio_in_o[PIN_INDEX], 1'b0);
		end
	endtask
	task automatic t_master();
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys_i);
			spi_out_i.master <= 1'b1;
			spi_out_i.sclk <= i[0];
			spi_out_i.mosi <= i[1];
			tick(1);
			chk_bit(pads_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN].out, i[0]);
			chk_bit(pads_o[PIN_SPI_ZERO_MASTER_OUT_PIN].out, i[1]);
			chk_bit(pads_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN].oe & pads_o[PIN_SPI_ZERO_MASTER_OUT_PIN].oe, 1'b1);
			chk_bit(pads_o[PIN_SPI_ZERO_MASTER_IN_PIN].oe, 1'b0);
		end
	endtask
	task automatic t_slave();
		@(posedge clk_sys_i);
		spi_out_i.master <= 1'b0;
		spi_out_i.miso <= 1'b0;
		peer_en[PIN_SS0] <= 1'b1;
		peer_en[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] <= 1'b1;
		peer_val[PIN_SPI_ZERO_SERIAL_CLOCK_PIN] <= 1'b0;
		peer_en[PIN_SPI_ZERO_MASTER_OUT_PIN] <= 1'b1;
		peer_val[PIN_SPI_ZERO_MASTER_OUT_PIN] <= 1'b0;
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk_sys_i);
			peer_val[PIN_SS0] <= s[0];
			tick(3);
			chk_bit(pads_o[PIN_SPI_ZERO_MASTER_IN_PIN].oe, !s[0]);
			chk_bit(spi_slave_selected_o, !s[0]);
		end
		chk_bit(pads_o[PIN_SPI_ZERO_MASTER_IN_PIN].out, 1'b0);
		chk_bit(pads_o[PIN_SPI_ZERO_SERIAL_CLOCK_PIN].oe | spi_in_o.sclk, 1'b0);
		chk_bit(spi_in_o.mosi, 1'b0);
		@(posedge clk_sys_i);
		peer_val[PIN_SS0] <= 1'b1;
	endtask
	task automatic t_alt();
		@(posedge clk_sys_i);
		peer_en[PIN_SPI_ZERO_MASTER_IN_PIN] <= 1'b1;
		peer_val[PIN_SPI_ZERO_MASTER_IN_PIN] <= 1'b0;
		ld(PIN_SPI_ZERO_MASTER_IN_PIN, FN_1);
		ld(PIN_SS0, FN_1);
		chk_bit(serial_one_receive_input_o, 1'b0);
		chk_bit(spi_in_o.miso & spi_in_o.select_n, 1'b1);
		chk_bit(pads_o[PIN_SS0].oe & ~pads_o[PIN_SS0].out, 1'b1);
		@(posedge clk_sys_i);
		serial_one_transmit_output_i <= 1'b1;
		tick(1);
		chk_bit(pads_o[PIN_SS0].out, 1'b1);
	endtask
	task automatic t_pwm();
		logic [FN_W-1:0] codes [3] = '{FN_0, FN_1, FN_NONE};
		@(posedge clk_sys_i);
		pwm_channel_zero_output_i <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			ld(PIN_PWM0, codes[i]);
			chk_bit(pads_o[PIN_PWM0].oe, i < 2);
			chk_bit(pads_o[PIN_PWM0].out & (i < 2), i == 1);
		end
	endtask
	initial begin
		t_reset(1'b0);
		t_reset(1'b1);
		t_shared();
		t_gpio();
		t_master();
		t_slave();
		t_alt();
		t_pwm();
		give_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		miscompares++;
		give_verdict();
	end
endmodule
